// ---- dv/mcu_power_reset_sequencer_tb.sv ----
// Testbench for the machine-cycle, power-mode and reset sequencer.
`timescale 1ns/1ps
module mcu_power_reset_sequencer_tb;
    import mprs_pkg::*;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, pull = 0;
    logic        ilast = 1, por_pin = 0, need_code_byte = 1, xmove_instr = 0;
    logic        ext_prog_mem = 1, pc_load = 0, sp_wr = 0, err;
    logic [7:0]  paddr = '0, irq_src = '0, sp_wdata = '0, sp, port_reset_data;
    logic [15:0] pc_load_value = '0, pc, irq_vector;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, rst_pin, core_rst, cpu_clk_en, periph_clk_en;
    logic        idle_active, pd_active, fetch_strobe;
    logic [1:0]  ext_int_n;
    int          fail_count = 0, total_checks = 0, n;
    mprs_ext_model u_ext (.core_clk, .fire_rst(fire), .pull_int(pull), .rst_pin, .ext_int_n);
    mprs_seq u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rst_pin, .por_pin, .ext_int_n, .irq_src, .need_code_byte,
        .instr_last(ilast), .xmove_instr, .ext_prog_mem, .pc_load, .pc_load_value, .sp_wr,
        .sp_wdata, .core_rst, .cpu_clk_en, .periph_clk_en, .idle_active, .pd_active,
        .fetch_strobe, .opcode_latch(), .exec_done(), .program_read_strobe_n(), .pc, .sp,
        .port_preset(), .port_reset_data, .irq_req(), .irq_vector);
    initial forever #20 core_clk = ~core_clk;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic sig(input int k);
        case (k)
            0: return !core_rst;
            1: return idle_active;
            2: return pd_active;
            3: return !idle_active;
            5: return !pd_active;
            default: return core_rst;
        endcase
    endfunction : sig
    task automatic wait_for(input int k);
        n = 0;
        while (sig(k) !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("wait bound", n < 3000, 1);
        if (n >= 3000) wrap_up();
        @(posedge core_clk);
    endtask : wait_for
    // Request held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("apb bound", n < 50, 1);
        if (n >= 50) wrap_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_for(0);
        chk("pc", {16'h0000, pc}, PC_RESET);
        chk("sp", sp, SP_RESET);
        chk("ports", port_reset_data, PORT_RESET);
        apb(0, A_RST_CAUSE, 0);
        chk("cause", rd, 32'h0000_0001);
        apb(0, 8'h40, 0);
        chk("unmapped", err, 1);
        // Both gaps S1P2 to S4P2 and S4P2 to S1P2 span three states.
        for (int g = 0; g < 3; g++) begin
            n = 0;
            do begin
                @(posedge core_clk);
                #1;
                n++;
            end while (fetch_strobe !== 1'b1 && n < 20);
            chk("fetch bound", n < 20, 1);
            if (n >= 20) wrap_up();
            if (g > 0) chk("fetch gap", n, 6);
        end
        @(posedge core_clk);
        apb(1, A_PWR_CTRL, 1);
        wait_for(1);
        chk("cpu clk idle", cpu_clk_en, 0);
        chk("periph clk idle", periph_clk_en, 1);
        apb(1, A_INT_EN, 32'h0000_0102);
        irq_src <= 8'h02;
        @(posedge core_clk);
        irq_src <= 8'h00;
        wait_for(3);
        chk("vector", irq_vector, VEC_BASE + 16'h0008);
        apb(0, A_PWR_CTRL, 0);
        chk("idle bit", rd, 0);
        apb(1, A_INT_FLAG, 2);
        apb(1, A_INT_MODE, 1);
        apb(1, A_INT_EN, 32'h0000_0101);
        apb(1, A_PWR_CTRL, 2);
        wait_for(2);
        pull <= 1'b1;
        wait_for(5);
        pull <= 1'b0;
        apb(0, A_PWR_CTRL, 0);
        chk("pd bit", rd, 0);
        apb(1, A_PWR_CTRL, 3);
        wait_for(2);
        chk("periph clk pd", periph_clk_en, 0);
        chk("no idle", idle_active, 0);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        wait_for(4);
        chk("pd left", pd_active, 0);
        @(posedge core_clk);
        chk("pc pd", {16'h0000, pc}, PC_RESET);
        wait_for(0);
        apb(0, A_PWR_CTRL, 0);
        chk("mode bits", rd, 0);
        apb(1, A_CHIP_PROG, 32'h0000_0083);
        wait_for(4);
        wait_for(0);
        apb(0, A_RST_CAUSE, 0);
        chk("sw cause", rd, 32'h0000_0005);
        apb(1, A_WDT_CTRL, 32'h0000_0003);
        wait_for(4);
        wait_for(0);
        chk("wdt hold", n, RST_HOLD_MC * OSC_PER_MC - 1);
        apb(0, A_RST_CAUSE, 0);
        chk("wdt cause", rd, 32'h0000_0007);
        apb(0, A_WDT_CTRL, 0);
        chk("wdt flag", rd, 32'h0000_0103);
        wrap_up();
    end
endmodule : mcu_power_reset_sequencer_tb

// ---- dv/mprs_ext_model.sv ----
// Model of the external reset circuit and the external interrupt pins.
`timescale 1ns/1ps
module mprs_ext_model (
    input  wire logic core_clk,  // Oscillator clock.
    input  wire logic fire_rst,  // Request one reset pulse.
    input  wire logic pull_int,  // Hold interrupt pin 0 low.
    output logic      rst_pin,   // External reset pin.
    output logic [1:0] ext_int_n // Interrupt pins, released high.
);
    int hold = 0;
    // The pin is held for a full two machine cycles so two samples see it.
    always @(posedge core_clk) begin
        if (fire_rst && hold == 0) hold <= 24;
        else if (hold != 0) hold <= hold - 1;
    end
    assign rst_pin = (hold != 0);
    assign ext_int_n = {1'b1, !pull_int};
endmodule : mprs_ext_model

// ---- logic/mprs_pkg.sv ----
// Constants and types shared by the power and reset sequencer.
package mprs_pkg;

    typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} mprs_state_t;

    localparam int          OSC_PER_STATE = 2;
    localparam int          STATES_PER_MC = 6;
    localparam int          OSC_PER_MC    = OSC_PER_STATE * STATES_PER_MC;
    localparam int          RST_HOLD_MC   = 2;
    localparam logic [4:0]  RST_HOLD_CYC  = 5'(RST_HOLD_MC * OSC_PER_MC);

    localparam logic [7:0]  A_PWR_CTRL    = 8'h00;
    localparam logic [7:0]  A_CHIP_PROG   = 8'h04;
    localparam logic [7:0]  A_INT_EN      = 8'h08;
    localparam logic [7:0]  A_INT_PRIO    = 8'h0C;
    localparam logic [7:0]  A_INT_FLAG    = 8'h10;
    localparam logic [7:0]  A_INT_MODE    = 8'h14;
    localparam logic [7:0]  A_WDT_CTRL    = 8'h18;
    localparam logic [7:0]  A_RST_CAUSE   = 8'h1C;
    localparam logic [7:0]  A_STATUS      = 8'h20;

    localparam int          PWR_IDLE_BIT  = 0;
    localparam int          PWR_PD_BIT    = 1;
    localparam logic [7:0]  SWRST_MASK    = 8'h83;
    localparam int          GIE_BIT       = 8;
    localparam int          EXT0_IDX      = 0;
    localparam int          EXT1_IDX      = 2;
    localparam int          WDT_RUN_BIT   = 0;
    localparam int          WDT_RSTEN_BIT = 1;
    localparam int          WDT_IVL_LO    = 2;
    localparam int          WDT_KICK_BIT  = 4;
    localparam int          WDT_FLAG_BIT  = 8;
    localparam int          CAUSE_POR     = 0;
    localparam int          CAUSE_WDT     = 1;
    localparam int          CAUSE_SW      = 2;
    localparam logic [2:0]  CAUSE_RESET   = 3'h1;

    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [7:0]  SP_RESET      = 8'h07;
    localparam logic [7:0]  PORT_RESET    = 8'hFF;
    localparam logic [15:0] VEC_BASE      = 16'h0003;

    localparam int          WDT_CNT_W     = 13;
    localparam logic [12:0] WDT_LIM0      = 13'h0040;
    localparam logic [12:0] WDT_LIM1      = 13'h0100;
    localparam logic [12:0] WDT_LIM2      = 13'h0400;
    localparam logic [12:0] WDT_LIM3      = 13'h1000;

endpackage : mprs_pkg

// ---- logic/mprs_seq.sv ----
// Machine-cycle sequencer, power modes, reset generation and wake-up interrupts.
// Overview of operation
// - six two-clock states make one machine cycle
// - two fetches per cycle, unused fetch ignored
// - opcode in S1, second fetch S4, end S6
// - external data move: no fetch second cycle
// - program read strobe twice, skipped during data move
// - power control bit 0 enters idle
// - idle stops CPU clock, peripherals keep running
// - enabled interrupt clears idle bit, ends idle
// - any reset ends idle immediately
// - power control bit 1 stops all clocks
// - reset pin high ends power-down, restarts
// - enabled level external interrupt wakes power-down
// - reset pin sampled at fifth state second phase
// - reset lasts while pin high plus two cycles
// - watchdog counts, restarts, flags and resets
// - watchdog reset held two machine cycles
// - chip programming bits 0,1,7 reset CPU
// - reset forces PC 0000h, SP 07h
// - reset clears registers except watchdog setup and cause flags, ports load FFh
// - reset cause flags readable by software
// - eight sources, two priorities, global enable
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module mprs_seq
    import mprs_pkg::*;
(
    input  wire logic        core_clk,              // Oscillator clock.
    input  wire logic        rst,                   // Synchronous reset, high.
    input  wire logic        psel,                  // APB select.
    input  wire logic        penable,               // APB enable.
    input  wire logic        pwrite,                // APB direction.
    input  wire logic [7:0]  paddr,                 // APB byte address.
    input  wire logic [31:0] pwdata,                // APB write data.
    output logic [31:0]      prdata,                // APB read data.
    output logic             pready,                // APB ready.
    output logic             pslverr,               // APB error.
    input  wire logic        rst_pin,               // External reset pin.
    input  wire logic        por_pin,               // Power-on detector.
    input  wire logic [1:0]  ext_int_n,             // External interrupt pins, low.
    input  wire logic [7:0]  irq_src,               // Interrupt set pulses.
    input  wire logic        need_code_byte,        // Core wants the fetched byte.
    input  wire logic        instr_last,            // Current cycle ends instruction.
    input  wire logic        xmove_instr,           // External data move in progress.
    input  wire logic        ext_prog_mem,          // Program memory is external.
    input  wire logic        pc_load,               // Core loads the PC.
    input  wire logic [15:0] pc_load_value,         // New PC value.
    input  wire logic        sp_wr,                 // Core writes the SP.
    input  wire logic [7:0]  sp_wdata,              // New SP value.
    output logic             core_rst,              // Internal reset.
    output logic             cpu_clk_en,            // CPU clock enable.
    output logic             periph_clk_en,         // Peripheral clock enable.
    output logic             idle_active,           // Idle mode.
    output logic             pd_active,             // Power-down mode.
    output logic             fetch_strobe,          // Program fetch pulse.
    output logic             opcode_latch,          // Opcode latch pulse.
    output logic             exec_done,             // Instruction end pulse.
    output logic             program_read_strobe_n, // External fetch strobe, low.
    output logic [15:0]      pc,                    // Program counter.
    output logic [7:0]       sp,                    // Stack pointer.
    output logic             port_preset,           // Ports load preset value.
    output logic [7:0]       port_reset_data,       // Port preset value.
    output logic             irq_req,               // Interrupt request.
    output logic [15:0]      irq_vector             // Vector of the winner.
);
    mprs_state_t st;
    logic        ph;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        ext_rst_s;
    logic        por_s;
    logic [1:0]  ext_low;
    logic [1:0]  ext_prev;
    logic        mc_end;
    logic        sample_pt;
    logic        fetch_pt;
    logic        cpu_run;
    logic [4:0]  hold_cnt;
    logic        rst_src;
    logic        sw_rst_q;
    logic        wdt_rst;
    logic        wdt_timeout;
    logic [2:0]  cause;
    logic [1:0]  pwr;
    logic [7:0]  chip_prog;
    logic [7:0]  int_en;
    logic        gie;
    logic [7:0]  int_prio;
    logic [1:0]  int_mode;
    logic [7:0]  int_flag;
    logic [7:0]  set_vec;
    logic [7:0]  pending;
    logic        pend_any;
    logic        wake_int;
    logic [2:0]  win;
    logic [3:0]  wdt_ctrl;
    logic        wdt_flag;
    logic        xmove_second;
    logic        new_instr;
    logic        wr;
    logic        hit;
    logic [31:0] next_prdata;

    function automatic mprs_state_t next_st(input mprs_state_t s);
        unique case (s)
            ST_S1: return ST_S2;
            ST_S2: return ST_S3;
            ST_S3: return ST_S4;
            ST_S4: return ST_S5;
            ST_S5: return ST_S6;
            ST_S6: return ST_S1;
        endcase
    endfunction : next_st

    function automatic logic [2:0] pick(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : pick

    // Pins are asynchronous; only sync2 is read by logic.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1 <= 4'h3;
            sync2 <= 4'h3;
        end else begin
            sync1 <= {rst_pin, por_pin, ext_int_n};
            sync2 <= sync1;
        end
    end
    assign ext_rst_s = sync2[3];
    assign por_s     = sync2[2];
    assign ext_low   = ~sync2[1:0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= ST_S1;
            ph <= 1'b0;
        end else if (!pd_active) begin
            ph <= !ph;
            if (ph) begin
                st <= next_st(st);
            end
        end
    end
    // Frozen state in power-down must not look like a cycle end.
    assign mc_end    = (st == ST_S6) && ph && !pd_active;
    assign sample_pt = (st == ST_S5) && ph && !pd_active;
    assign fetch_pt  = !ph && ((st == ST_S1) || (st == ST_S4));
    assign cpu_run   = !idle_active && !pd_active && !core_rst;

    // External pin counts only at the sample point; in power-down the
    // sequencer is stopped, so a high pin restarts it directly.
    assign rst_src = por_s || (sample_pt && ext_rst_s) || (pd_active && ext_rst_s)
                     || wdt_rst || sw_rst_q;

    always_ff @(posedge core_clk) begin
        if (rst || rst_src) begin
            hold_cnt <= RST_HOLD_CYC;
        end else if (hold_cnt != 5'h00) begin
            hold_cnt <= hold_cnt - 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_rst <= 1'b1;
        end else begin
            core_rst <= rst_src || (hold_cnt > 5'h01);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause <= CAUSE_RESET;
        end else begin
            if (wr && paddr == A_RST_CAUSE) begin
                cause <= cause & ~pwdata[2:0];
            end
            if (por_s) cause[CAUSE_POR] <= 1'b1;
            if (wdt_rst) cause[CAUSE_WDT] <= 1'b1;
            if (sw_rst_q) cause[CAUSE_SW] <= 1'b1;
        end
    end

    assign wr = psel && penable && pwrite;

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            pwr <= 2'h0;
        end else begin
            if (wr && paddr == A_PWR_CTRL) begin
                pwr <= pwdata[1:0];
            end
            if (idle_active && pend_any) pwr[PWR_IDLE_BIT] <= 1'b0;
            if (pd_active && wake_int) pwr[PWR_PD_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            idle_active <= 1'b0;
        end else if (idle_active && pend_any) begin
            idle_active <= 1'b0;
        end else if (mc_end && instr_last && pwr[PWR_IDLE_BIT] && !pwr[PWR_PD_BIT]) begin
            idle_active <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            pd_active <= 1'b0;
        end else if (pd_active && (wake_int || ext_rst_s || por_s)) begin
            pd_active <= 1'b0;
        end else if (mc_end && instr_last && pwr[PWR_PD_BIT] && !idle_active) begin
            pd_active <= 1'b1;
        end
    end

    // Gating the CPU clock keeps core registers and port levels frozen.
    assign cpu_clk_en    = !idle_active && !pd_active;
    assign periph_clk_en = !pd_active;

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            xmove_second <= 1'b0;
            new_instr    <= 1'b1;
        end else if (mc_end && cpu_run) begin
            xmove_second <= xmove_instr && !xmove_second;
            new_instr    <= instr_last;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_strobe          <= 1'b0;
            opcode_latch          <= 1'b0;
            exec_done             <= 1'b0;
            program_read_strobe_n <= 1'b1;
        end else begin
            fetch_strobe <= cpu_run && fetch_pt && !xmove_second;
            opcode_latch <= cpu_run && new_instr && !ph && st == ST_S1;
            exec_done    <= cpu_run && mc_end && instr_last;
            program_read_strobe_n <= !(ext_prog_mem && cpu_run && !xmove_second
                                       && (st == ST_S1 || st == ST_S4));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            pc <= PC_RESET;
        end else if (cpu_run && pc_load) begin
            pc <= pc_load_value;
        end else if (cpu_run && fetch_pt && !xmove_second && need_code_byte) begin
            pc <= pc + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            sp <= SP_RESET;
        end else if (sp_wr && cpu_clk_en) begin
            sp <= sp_wdata;
        end
    end

    assign port_preset     = core_rst;
    assign port_reset_data = PORT_RESET;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_prev <= 2'h0;
        end else begin
            ext_prev <= ext_low;
        end
    end

    always_comb begin
        set_vec           = irq_src;
        set_vec[EXT0_IDX] = int_mode[0] ? ext_low[0] : (ext_low[0] && !ext_prev[0]);
        set_vec[EXT1_IDX] = int_mode[1] ? ext_low[1] : (ext_low[1] && !ext_prev[1]);
    end

    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (rst || core_rst) begin
                int_flag[i] <= 1'b0;
            end else if (set_vec[i]) begin
                int_flag[i] <= 1'b1;
            end else if (wr && paddr == A_INT_FLAG && pwdata[i]) begin
                int_flag[i] <= 1'b0;
            end
        end
    end

    assign pending  = int_flag & int_en & {8{gie}};
    assign pend_any = |pending;
    assign win      = (|(pending & int_prio)) ? pick(pending & int_prio) : pick(pending);
    assign wake_int = gie && ((ext_low[0] && int_en[EXT0_IDX] && int_mode[0])
                           || (ext_low[1] && int_en[EXT1_IDX] && int_mode[1]));

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            irq_req    <= 1'b0;
            irq_vector <= VEC_BASE;
        end else begin
            irq_req    <= pend_any;
            irq_vector <= VEC_BASE + {10'h000, win, 3'h0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || core_rst) begin
            chip_prog <= 8'h00;
            int_en    <= 8'h00;
            gie       <= 1'b0;
            int_prio  <= 8'h00;
            int_mode  <= 2'h0;
        end else if (wr) begin
            if (paddr == A_CHIP_PROG) chip_prog <= pwdata[7:0];
            if (paddr == A_INT_EN) begin
                int_en <= pwdata[7:0];
                gie    <= pwdata[GIE_BIT];
            end
            if (paddr == A_INT_PRIO) int_prio <= pwdata[7:0];
            if (paddr == A_INT_MODE) int_mode <= pwdata[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= wr && paddr == A_CHIP_PROG
                        && (pwdata[7:0] & SWRST_MASK) == SWRST_MASK;
        end
    end

    // Only a power-on clears the watchdog setup, so it survives other resets.
    always_ff @(posedge core_clk) begin
        if (rst || por_s) begin
            wdt_ctrl <= 4'h0;
            wdt_flag <= 1'b0;
        end else begin
            if (wr && paddr == A_WDT_CTRL) begin
                wdt_ctrl <= pwdata[3:0];
                if (pwdata[WDT_FLAG_BIT]) wdt_flag <= 1'b0;
            end
            if (wdt_timeout) wdt_flag <= 1'b1;
        end
    end

    mprs_watchdog u_wdt (
        .core_clk (core_clk),
        .rst      (rst || por_s),
        .tick     (mc_end),
        .run      (wdt_ctrl[WDT_RUN_BIT]),
        .rst_en   (wdt_ctrl[WDT_RSTEN_BIT]),
        .interval (wdt_ctrl[WDT_IVL_LO +: 2]),
        .kick     (wr && paddr == A_WDT_CTRL && pwdata[WDT_KICK_BIT]),
        .timeout  (wdt_timeout),
        .wdt_rst  (wdt_rst)
    );

    always_comb begin
        hit         = 1'b1;
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            A_PWR_CTRL:  next_prdata[1:0] = pwr;
            A_CHIP_PROG: next_prdata[7:0] = chip_prog;
            A_INT_EN:    next_prdata[8:0] = {gie, int_en};
            A_INT_PRIO:  next_prdata[7:0] = int_prio;
            A_INT_FLAG:  next_prdata[7:0] = int_flag;
            A_INT_MODE:  next_prdata[1:0] = int_mode;
            A_WDT_CTRL:  next_prdata[8:0] = {wdt_flag, 4'h0, wdt_ctrl};
            A_RST_CAUSE: next_prdata[2:0] = cause;
            A_STATUS:    next_prdata = {pc, 8'h00, 1'b0, core_rst, pd_active,
                                        idle_active, ph, st};
            default:     hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Clocks since the last cycle end; frozen with the sequencer in power-down.
    logic [3:0] mc_gap;
    always_ff @(posedge core_clk) begin
        if (rst || mc_end) begin
            mc_gap <= 4'h0;
        end else if (!pd_active) begin
            mc_gap <= mc_gap + 4'h1;
        end
    end

    a_mc_twelve: assert property (mc_end |-> mc_gap == 4'hB)
        else $error("machine cycle is not twelve clocks");
    a_fetch_space: assert property (fetch_strobe |=> (!fetch_strobe) [*5])
        else $error("fetches closer than six clocks");
    a_opcode_s1: assert property (opcode_latch |-> $past(st) == ST_S1 && !$past(ph))
        else $error("opcode latched outside S1");
    a_xmove_nofetch: assert property (fetch_strobe |-> !$past(xmove_second))
        else $error("fetch in second data move cycle");
    a_strobe_skip: assert property (!program_read_strobe_n |->
        $past(ext_prog_mem) && !$past(xmove_second))
        else $error("program read strobe not skipped");
    a_idle_clocks: assert property (idle_active |-> !cpu_clk_en && periph_clk_en)
        else $error("idle clock gating wrong");
    a_idle_wake: assert property (idle_active && pend_any && !core_rst
        |=> !idle_active && !pwr[PWR_IDLE_BIT])
        else $error("interrupt did not end idle");
    a_pd_pin_wake: assert property (pd_active && ext_rst_s |=> !pd_active ##1 core_rst)
        else $error("reset pin did not end power-down");
    a_pd_int_wake: assert property (pd_active && wake_int |=> !pd_active)
        else $error("level interrupt did not wake");
    a_rst_hold: assert property (rst_src |=> core_rst [*8])
        else $error("internal reset released early");
    a_sw_reset: assert property (wr && paddr == A_CHIP_PROG && pwdata[7:0] == SWRST_MASK
        |=> ##1 core_rst)
        else $error("software reset missing");
    a_rst_state: assert property (core_rst |=> pc == PC_RESET && sp == SP_RESET
        && !idle_active)
        else $error("reset state wrong");
    a_pd_wins: assert property (mc_end && instr_last && pwr == 2'h3 && !core_rst
        && !idle_active |=> pd_active && !idle_active)
        else $error("power-down did not win");
    a_irq_vector: assert property (irq_req |-> irq_vector[2:0] == 3'h3)
        else $error("vector misaligned");

    c_idle_wake: cover property (idle_active ##1 !idle_active && !core_rst);
    c_pd_wake: cover property (pd_active && wake_int);
    c_wdt_reset: cover property (wdt_rst ##1 core_rst);
    c_xmove: cover property (xmove_second && mc_end);

endmodule : mprs_seq

// ---- logic/mprs_watchdog.sv ----
// Free-running watchdog counting machine cycles.
`timescale 1ns/1ps
module mprs_watchdog
    import mprs_pkg::*;
(
    input  wire logic       core_clk, // Oscillator clock.
    input  wire logic       rst,      // Synchronous clear, high.
    input  wire logic       tick,     // One pulse per machine cycle.
    input  wire logic       run,      // Counter enable.
    input  wire logic       rst_en,   // Reset on time-out enable.
    input  wire logic [1:0] interval, // Time-out select.
    input  wire logic       kick,     // Software restart pulse.
    output logic            timeout,  // Time-out pulse.
    output logic            wdt_rst   // Reset request pulse.
);
    logic [WDT_CNT_W-1:0] cnt;
    logic [WDT_CNT_W-1:0] lim;
    logic                 hit;

    always_comb begin
        unique case (interval)
            2'd0: lim = WDT_LIM0;
            2'd1: lim = WDT_LIM1;
            2'd2: lim = WDT_LIM2;
            2'd3: lim = WDT_LIM3;
        endcase
    end

    assign hit = tick && (cnt == lim - 13'h0001);

    always_ff @(posedge core_clk) begin
        if (rst || kick || !run) begin
            cnt <= '0;
        end else if (hit) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= cnt + 13'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            timeout <= 1'b0;
            wdt_rst <= 1'b0;
        end else begin
            timeout <= hit && !kick;
            wdt_rst <= hit && !kick && rst_en;
        end
    end

    a_wdt_rst_cause: assert property (@(posedge core_clk) disable iff (rst)
        wdt_rst |-> timeout && $past(rst_en))
        else $error("watchdog reset without enabled time-out");
    a_wdt_kick_clr: assert property (@(posedge core_clk) disable iff (rst)
        kick |=> cnt == '0 && !timeout)
        else $error("watchdog restart did not clear the count");

endmodule : mprs_watchdog
